/* File: rtl/tco_overhead_inserter.sv */
/*
 * tandem connection source: rewrites N1 in every container frame and
 * compensates B3, with an AXI4-Lite slave for control, status and trace.
 * assumes the container clock is an asynchronous pin sampled here, with
 * data and frame start changing well away from its rising edge, and the
 * sink-side request and value inputs coming from logic on this clock.
 */
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tco_overhead_inserter (
	// clock and reset
	input logic clock,
	input logic sys_rst,
	// axi4-lite write
	input logic [tco_pkg::ADDR_W-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	// axi4-lite read
	input logic [tco_pkg::ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	// incoming container
	input logic container_clock_in,
	input logic [7:0] container_data_in,
	input logic container_frame_start_in,
	input logic incoming_signal_fail,
	// companion sink indications
	input logic remote_defect_request,
	input logic remote_error_value,
	input logic outgoing_defect_request,
	input logic outgoing_error_value,
	// outgoing container
	output logic container_clock_out,
	output logic [7:0] container_data_out,
	output logic container_frame_start_out,
	output logic container_out_valid,
	input logic container_out_ready
);
	// pin synchronisers: stage 1 is read only by stage 2
	logic [2:0] ck_s_q;
	logic [9:0] in_s1_q;
	logic [9:0] in_s2_q;

	always_ff @(posedge clock) begin
		ck_s_q <= {ck_s_q[1:0], container_clock_in};
		in_s1_q <= {container_frame_start_in, incoming_signal_fail, container_data_in};
		in_s2_q <= in_s1_q;
	end

	wire byte_ev = ck_s_q[1] && !ck_s_q[2];
	wire byte_fs = in_s2_q[9];
	wire byte_sf = in_s2_q[8];
	wire [7:0] din = in_s2_q[7:0];

	// registers
	logic [31:0] ctrl_q;
	logic [31:0] trace_q [tco_pkg::TRACE_WORDS];
	logic ovf_q;
	wire en = ctrl_q[tco_pkg::CTRL_EN_BIT];
	wire [127:0] trace_vec = {trace_q[0], trace_q[1], trace_q[2], trace_q[3]};

	// frame state
	logic [11:0] ix_q;
	logic [6:0] mf_q;
	logic [7:0] bip_acc_q;
	logic [7:0] prev_bip_q;
	logic [3:0] iec_q;
	logic rei_q;
	logic oei_q;
	logic rdi_q;
	logic odi_q;
	logic sf_q;
	logic [7:0] b3_in_prev_q;
	logic [7:0] b3_out_prev_q;
	logic [7:0] n1_in_prev_q;
	logic [7:0] n1_out_prev_q;

	function automatic logic [3:0] ones(input logic [7:0] v);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	wire at_b3 = !byte_fs && (ix_q == tco_pkg::B3_IDX);
	wire at_n1 = !byte_fs && (ix_q == tco_pkg::N1_IDX);
	wire [3:0] mism = ones(prev_bip_q ^ din);
	wire [3:0] iec_d = sf_q ? tco_pkg::IEC_SF :
		(mism == 4'h0) ? tco_pkg::IEC_ZERO : mism;

	// multiframed channel content, bits 7 and 8
	wire [5:0] tr_k = 6'(mf_q - tco_pkg::TRACE_FIRST);
	wire [6:0] tr_hi = ~{tr_k, 1'b0};
	wire [6:0] tr_lo = ~{tr_k, 1'b1};
	wire is_fas = (mf_q <= tco_pkg::FAS_LAST);
	wire is_trace = (mf_q >= tco_pkg::TRACE_FIRST) && (mf_q <= tco_pkg::TRACE_LAST);
	wire [1:0] fas_bits = (mf_q == tco_pkg::FAS_LAST) ? tco_pkg::FAS_END_BITS :
		tco_pkg::FAS_BITS;
	wire [1:0] trace_bits = {trace_vec[tr_hi], trace_vec[tr_lo]};
	// one means defect, zero normal; other reserved positions stay zero
	wire [1:0] tail_bits = (mf_q == tco_pkg::RDI_FRAME) ? {1'b0, rdi_q} :
		(mf_q == tco_pkg::ODI_FRAME) ? {odi_q, 1'b0} : 2'b00;
	wire [1:0] mf_bits = is_fas ? fas_bits : is_trace ? trace_bits : tail_bits;
	wire [7:0] n1_new = {iec_q, rei_q, oei_q, mf_bits};
	// compensation keeps downstream path monitors happy after N1 is rewritten
	wire [7:0] b3_new = b3_in_prev_q ^ b3_out_prev_q ^ n1_in_prev_q ^ n1_out_prev_q ^ din;
	wire [7:0] out_byte = !en ? din : at_b3 ? b3_new : at_n1 ? n1_new : din;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ix_q <= '0;
			mf_q <= tco_pkg::MF_LEN;
			bip_acc_q <= '0;
			prev_bip_q <= '0;
			iec_q <= tco_pkg::IEC_ZERO;
			{rei_q, oei_q, rdi_q, odi_q, sf_q} <= '0;
		end else if (byte_ev) begin
			if (byte_fs) begin
				ix_q <= 12'h001;
				mf_q <= (mf_q == tco_pkg::MF_LEN) ? tco_pkg::MF_FIRST : mf_q + 7'h01;
				prev_bip_q <= bip_acc_q;
				bip_acc_q <= din;
				// requests are sampled once a frame, so set and clear land in
				// the next multiframe slot at the latest
				rdi_q <= remote_defect_request;
				odi_q <= outgoing_defect_request;
				rei_q <= remote_error_value;
				oei_q <= outgoing_error_value;
				sf_q <= byte_sf;
			end else begin
				ix_q <= (ix_q == tco_pkg::IDX_MAX) ? ix_q : ix_q + 12'h001;
				bip_acc_q <= bip_acc_q ^ din;
				if (at_b3) begin
					iec_q <= iec_d;
				end
				if (byte_sf) begin
					sf_q <= 1'b1;
				end
			end
		end
	end

	// history for the compensation: the byte as received and as sent
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			b3_in_prev_q <= '0;
			b3_out_prev_q <= '0;
			n1_in_prev_q <= '0;
			n1_out_prev_q <= '0;
		end else if (byte_ev && at_b3) begin
			b3_in_prev_q <= din;
			b3_out_prev_q <= out_byte;
		end else if (byte_ev && at_n1) begin
			n1_in_prev_q <= din;
			n1_out_prev_q <= out_byte;
		end
	end

	// two-entry buffer toward the downstream stage
	wire buf_in_ready;
	wire [8:0] buf_in_data = {byte_fs, out_byte};
	wire ob_valid;
	wire [8:0] ob_data;
	wire ob_ready = !container_out_valid || container_out_ready;

	tco_pair_buffer #(
		.WIDTH(9),
		.DEPTH(2)
	) i_tco_pair_buffer (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(byte_ev),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(ob_valid),
		.out_ready(ob_ready),
		.out_data(ob_data)
	);

	// the pin cannot be stalled, so a byte that meets a full buffer is lost
	// and only the sticky overflow flag tells software
	wire ovf_set = byte_ev && !buf_in_ready;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			container_out_valid <= 1'b0;
			container_clock_out <= 1'b0;
			container_data_out <= '0;
			container_frame_start_out <= 1'b0;
		end else begin
			container_clock_out <= ob_valid && ob_ready;
			if (ob_valid && ob_ready) begin
				container_out_valid <= 1'b1;
				container_data_out <= ob_data[7:0];
				container_frame_start_out <= ob_data[8];
			end else if (container_out_ready) begin
				container_out_valid <= 1'b0;
			end
		end
	end

	// axi4-lite write side: address and data taken in either order
	logic aw_held_q;
	logic w_held_q;
	logic [tco_pkg::ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
	wire [3:0] wr_idx = awaddr_q[5:2];
	wire wr_hit = (wr_idx <= tco_pkg::LAST_WORD_IDX);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nv[b*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tco_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? tco_pkg::RESP_OKAY : tco_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	wire wr_ctrl = do_write && (awaddr_q[5:2] == tco_pkg::OFF_CTRL[5:2]);
	wire wr_status = do_write && (awaddr_q[5:2] == tco_pkg::OFF_STATUS[5:2]);
	localparam int ST_OVF_LANE = tco_pkg::ST_OVF_BIT / 8;
	wire ovf_clr = wr_status && wstrb_q[ST_OVF_LANE] && wdata_q[tco_pkg::ST_OVF_BIT];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_q <= tco_pkg::CTRL_RESET;
			ovf_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end
			// a loss in the clearing cycle keeps the flag set
			ovf_q <= ovf_set || (ovf_q && !ovf_clr);
		end
	end

	genvar g;
	generate
		for (g = 0; g < tco_pkg::TRACE_WORDS; g++) begin : gen_trace
			wire hit = do_write && (wr_idx == 4'(g + 2));
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					trace_q[g] <= tco_pkg::TRACE_RESET;
				end else if (hit) begin
					trace_q[g] <= merge(trace_q[g], wdata_q, wstrb_q);
				end
			end
		end
	endgenerate

	// axi4-lite read side
	wire [3:0] rd_idx = s_axi_araddr[5:2];
	wire [1:0] rd_tidx = 2'(rd_idx - 4'h2);
	wire rd_hit = (rd_idx <= tco_pkg::LAST_WORD_IDX);
	wire [31:0] status_word = (32'(mf_q) << tco_pkg::ST_MF_LSB) |
		(32'(iec_q) << tco_pkg::ST_IEC_LSB) | (32'(ovf_q) << tco_pkg::ST_OVF_BIT);
	wire [31:0] rd_word = !rd_hit ? 32'h0000_0000 :
		(rd_idx == 4'h0) ? ctrl_q : (rd_idx == 4'h1) ? status_word : trace_q[rd_tidx];

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= tco_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? tco_pkg::RESP_OKAY : tco_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks on the inserted overhead and the sticky overflow flag
	wire n1_push = byte_ev && at_n1 && en;
	wire b3_push = byte_ev && at_b3 && en;

	a_mf_wrap: assert property (@(posedge clock) disable iff (sys_rst)
		(byte_ev && byte_fs && mf_q == 7'h4C) |=> (mf_q == 7'h01))
		else $error("multiframe counter did not wrap to one");
	a_mf_step: assert property (@(posedge clock) disable iff (sys_rst)
		(byte_ev && byte_fs && mf_q < 7'h4C) |=> (mf_q == $past(mf_q) + 7'h01))
		else $error("multiframe counter did not advance");
	a_fas_pattern: assert property (@(posedge clock) disable iff (sys_rst)
		(n1_push && mf_q >= 7'h01 && mf_q <= 7'h08) |->
		(buf_in_data[1:0] == ((mf_q == 7'h08) ? 2'b10 : 2'b11)))
		else $error("alignment pattern wrong in N1");
	a_rdi_odi_bits: assert property (@(posedge clock) disable iff (sys_rst)
		(n1_push && (mf_q == 7'h49 || mf_q == 7'h4A)) |->
		(buf_in_data[1:0] == ((mf_q == 7'h49) ? {1'b0, rdi_q} : {odi_q, 1'b0})))
		else $error("defect indication bits wrong");
	a_rdi_follows: assert property (@(posedge clock) disable iff (sys_rst)
		(byte_ev && byte_fs) |=> (rdi_q == $past(remote_defect_request) &&
		odi_q == $past(outgoing_defect_request)))
		else $error("defect request not sampled at frame start");
	a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
		(n1_push && mf_q >= 7'h4B && mf_q <= 7'h4C) |-> (buf_in_data[1:0] == 2'b00))
		else $error("reserved channel bits not zero");
	a_error_copy: assert property (@(posedge clock) disable iff (sys_rst)
		(n1_push) |-> (buf_in_data[3] == rei_q && buf_in_data[2] == oei_q))
		else $error("error indication bits not copied");
	a_iec_fail: assert property (@(posedge clock) disable iff (sys_rst)
		(byte_ev && at_b3 && sf_q) |=> (iec_q == 4'hE))
		else $error("signal fail code missing");
	a_iec_nonzero: assert property (@(posedge clock) disable iff (sys_rst)
		(n1_push) |-> (buf_in_data[7:4] != 4'h0 && buf_in_data[7:4] <= 4'hE))
		else $error("error code all zero");
	a_b3_plain: assert property (@(posedge clock) disable iff (sys_rst)
		(b3_push && n1_in_prev_q == n1_out_prev_q) |->
		(buf_in_data[7:0] == (b3_in_prev_q ^ b3_out_prev_q ^ din)))
		else $error("parity compensation wrong");
	a_ovf_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		(ovf_set) |=> (ovf_q))
		else $error("lost byte not flagged");
endmodule

/* File: rtl/tco_pair_buffer.sv */
/*
 * small valid/ready buffer, flip-flop storage addressed by index.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module tco_pair_buffer #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// clock and reset
	input logic clock,
	input logic sys_rst,
	// filling side
	input logic in_valid,
	output logic in_ready,
	input logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (cnt_q != DEPTH_C);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

/* File: rtl/tco_pkg.sv */
/*
 * constants for the tandem connection overhead inserter: register map,
 * field positions, reset values and the container / multiframe geometry.
 * assumes a 32-bit AXI4-Lite register bus and a byte-wide container stream.
 */
package tco_pkg;
	// register map, byte addresses
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTRL = 6'h00;
	localparam logic [5:0] OFF_STATUS = 6'h04;
	localparam logic [5:0] OFF_TRACE0 = 6'h08;
	localparam int TRACE_WORDS = 4;
	localparam logic [3:0] LAST_WORD_IDX = 4'h5;
	// control fields
	localparam int CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] TRACE_RESET = 32'h0000_0000;
	// status fields
	localparam int ST_MF_LSB = 0;
	localparam int ST_IEC_LSB = 8;
	localparam int ST_OVF_BIT = 16;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// container geometry: index of a byte counted from the frame start byte
	localparam logic [11:0] B3_IDX = 12'h105;
	localparam logic [11:0] N1_IDX = 12'h828;
	localparam logic [11:0] IDX_MAX = 12'hFFF;
	// multiframe layout of N1 bits 7 and 8
	localparam logic [6:0] MF_FIRST = 7'h01;
	localparam logic [6:0] MF_LEN = 7'h4C;
	localparam logic [6:0] FAS_LAST = 7'h08;
	localparam logic [6:0] TRACE_FIRST = 7'h09;
	localparam logic [6:0] TRACE_LAST = 7'h48;
	localparam logic [6:0] RDI_FRAME = 7'h49;
	localparam logic [6:0] ODI_FRAME = 7'h4A;
	localparam logic [1:0] FAS_BITS = 2'h3;
	localparam logic [1:0] FAS_END_BITS = 2'h2;
	// incoming error codes
	localparam logic [3:0] IEC_ZERO = 4'h9;
	localparam logic [3:0] IEC_SF = 4'hE;
endpackage

/* File: verif/tco_overhead_inserter_test.sv */
/*
 * bench for the overhead inserter: registers, N1 fields, B3 and stalls.
 * assumes tco_source_model drives the container pins.
 */
`timescale 1ns/1ps
module tco_overhead_inserter_test;
	logic clock, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, run, stall;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, cyc;
	logic cin_clk, cin_fs, fail, rdi_req, rei, odi_req, oei;
	logic cout_clk, cout_fs, cout_valid, cout_ready;
	logic [7:0] cin_data, cout_data, b3_flip;
	logic [7:0] b3_in, n1_in, b3_out, n1_out, p_b3_in, p_n1_in, p_b3_out, p_n1_out;
	int in_idx, out_idx, n1_cnt, n_errors, samples_checked, n_strobe, n_taken;

	tco_overhead_inserter i_tco_overhead_inserter (.clock(clock), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .container_clock_in(cin_clk),
		.container_data_in(cin_data), .container_frame_start_in(cin_fs),
		.incoming_signal_fail(fail), .remote_defect_request(rdi_req),
		.remote_error_value(rei), .outgoing_defect_request(odi_req),
		.outgoing_error_value(oei), .container_clock_out(cout_clk),
		.container_data_out(cout_data), .container_frame_start_out(cout_fs),
		.container_out_valid(cout_valid), .container_out_ready(cout_ready));

	tco_source_model i_tco_source_model (.run(run), .b3_flip(b3_flip),
		.container_clock_in(cin_clk), .container_data_in(cin_data),
		.container_frame_start_in(cin_fs));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// downstream stalls one cycle in four without losing words at this rate
	always @(posedge clock) begin
		cyc <= cyc + 2'h1;
		cout_ready <= !stall && (cyc != 2'h0);
	end

	always @(posedge cin_clk) begin
		in_idx = cin_fs ? 0 : in_idx + 1;
		if (in_idx == int'(tco_pkg::B3_IDX)) b3_in = cin_data;
		if (in_idx == int'(tco_pkg::N1_IDX)) n1_in = cin_data;
	end

	always @(negedge clock) begin
		if (cout_clk) n_strobe++;
		if (cout_valid && cout_ready) begin
			n_taken++;
			out_idx = cout_fs ? 0 : out_idx + 1;
			if (out_idx == int'(tco_pkg::B3_IDX)) b3_out = cout_data;
			if (out_idx == int'(tco_pkg::N1_IDX)) begin
				n1_out = cout_data;
				n1_cnt++;
			end
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic ha, hw, pend;
		pend = 1'b1;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pend) begin
			@(negedge clock);
			ha = awvalid && awready;
			hw = wvalid && wready;
			pend = !bvalid;
			r = bresp;
			@(posedge clock);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (!pend) bready <= 1'b0;
		end
	endtask

	task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ha, pend;
		pend = 1'b1;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pend) begin
			@(negedge clock);
			ha = arvalid && arready;
			pend = !rvalid;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (ha) arvalid <= 1'b0;
			if (!pend) rready <= 1'b0;
		end
	endtask

	// sets the sink values and B3 error pattern for the next frame, then judges its N1
	task automatic frame_check(input logic [7:0] flip, input logic f, input logic re,
		input logic oe, input bit hist);
		int n, c0;
		logic [3:0] iec;
		@(posedge clock);
		b3_flip <= flip;
		fail <= f;
		rei <= re;
		oei <= oe;
		c0 = n1_cnt;
		n = 0;
		while (n1_cnt == c0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		if (n1_cnt == c0) n_errors++;
		iec = ($countones(flip) == 0) ? tco_pkg::IEC_ZERO : 4'($countones(flip));
		if (f) iec = tco_pkg::IEC_SF;
		if (hist) check("iec", 32'(n1_out[7:4]), 32'(iec));
		if (hist) check("b3", 32'(b3_out), 32'(p_b3_in ^ p_b3_out ^ p_n1_in ^ p_n1_out ^ b3_in));
		check("rei", 32'(n1_out[3]), 32'(re));
		check("oei", 32'(n1_out[2]), 32'(oe));
		check("fas", 32'(n1_out[1:0]), 32'(tco_pkg::FAS_BITS));
		p_b3_in = b3_in;
		p_n1_in = n1_in;
		p_b3_out = b3_out;
		p_n1_out = n1_out;
	endtask

	task automatic test_registers;
		logic [31:0] d;
		logic [1:0] r;
		axi_read(tco_pkg::OFF_CTRL, d, r);
		check("ctrl reset", d, tco_pkg::CTRL_RESET);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("mf reset", d & 32'h7F, 32'(tco_pkg::MF_LEN));
		check("iec reset", (d >> tco_pkg::ST_IEC_LSB) & 32'hF, 32'(tco_pkg::IEC_ZERO));
		axi_read(tco_pkg::OFF_TRACE0, d, r);
		check("trace reset", d, tco_pkg::TRACE_RESET);
		axi_write(tco_pkg::OFF_TRACE0 + 6'h04, 32'hA5A5_5A5A, 4'hF, r);
		axi_write(tco_pkg::OFF_TRACE0 + 6'h04, 32'h0000_00FF, 4'h1, r);
		axi_read(tco_pkg::OFF_TRACE0 + 6'h04, d, r);
		check("trace lanes", d, 32'hA5A5_5AFF);
		axi_write(6'h18, 32'hFFFF_FFFF, 4'hF, r);
		check("unmapped bresp", 32'(r), 32'(tco_pkg::RESP_SLVERR));
		axi_read(6'h18, d, r);
		check("unmapped rdata", d, 32'h0);
		check("unmapped rresp", 32'(r), 32'(tco_pkg::RESP_SLVERR));
	endtask

	task automatic test_first_frame;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		run <= 1'b1;
		frame_check(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("mf first", d & 32'h7F, 32'(tco_pkg::MF_FIRST));
	endtask

	task automatic test_zero_count;
		logic [31:0] d;
		logic [1:0] r;
		frame_check(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("iec status", (d >> tco_pkg::ST_IEC_LSB) & 32'hF, 32'(tco_pkg::IEC_ZERO));
	endtask

	task automatic test_full_count;
		// defect requests raised so the once-a-frame sampling is exercised
		@(posedge clock);
		rdi_req <= 1'b1;
		odi_req <= 1'b1;
		frame_check(8'hFF, 1'b0, 1'b0, 1'b1, 1'b1);
	endtask

	task automatic test_signal_fail;
		frame_check(8'h07, 1'b1, 1'b1, 1'b1, 1'b1);
	endtask

	task automatic test_single_error;
		logic [31:0] d;
		logic [1:0] r;
		frame_check(8'h01, 1'b0, 1'b0, 1'b0, 1'b1);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("mf fifth", d & 32'h7F, 32'(tco_pkg::MF_FIRST + 7'h04));
		check("no loss", (d >> tco_pkg::ST_OVF_BIT) & 32'h1, 32'h0);
		// every loaded word strobes once: loaded = taken plus the one still waiting
		@(negedge clock);
		#1;
		check("strobes", 32'(n_strobe), 32'(n_taken + int'(cout_valid && !cout_ready)));
	endtask

	task automatic test_overflow;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		stall <= 1'b1;
		repeat (64) @(posedge clock);
		@(negedge clock);
		check("held word", 32'(cout_valid), 32'h1);
		@(posedge clock);
		stall <= 1'b0;
		repeat (40) @(posedge clock);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("ovf set", (d >> tco_pkg::ST_OVF_BIT) & 32'h1, 32'h1);
		axi_write(tco_pkg::OFF_STATUS, 32'h0001_0000, 4'h4, r);
		axi_read(tco_pkg::OFF_STATUS, d, r);
		check("ovf cleared", (d >> tco_pkg::ST_OVF_BIT) & 32'h1, 32'h0);
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge clock);
		n_errors++;
		finish_test;
	end

	initial begin
		{sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata, wstrb} = 48'h0;
		{fail, rdi_req, rei, odi_req, oei, run, stall} = 7'h0;
		{b3_flip, cyc, cout_ready} = 11'h0;
		{in_idx, out_idx, n1_cnt, n_errors, samples_checked, n_strobe, n_taken} = '0;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		test_registers;
		test_first_frame;
		test_zero_count;
		test_full_count;
		test_signal_fail;
		test_single_error;
		test_overflow;
		finish_test;
	end
endmodule

/* File: verif/tco_source_model.sv */
/*
 * upstream source of container frames: a byte every 80 ns link clock,
 * frame start on byte 0, B3 as even parity of the whole previous frame.
 * assumes the bench raises run once and steers the B3 error pattern.
 */
`timescale 1ns/1ps
module tco_source_model #(
	parameter int FRAME_BYTES = 2092
) (
	// bench control
	input wire logic run,
	input wire logic [7:0] b3_flip,
	// container pins
	output logic container_clock_in,
	output logic [7:0] container_data_in,
	output logic container_frame_start_in
);
	logic [7:0] acc, prev, byte_v;
	int idx, fr;
	initial begin
		container_clock_in = 1'b0;
		container_data_in = 8'h00;
		container_frame_start_in = 1'b0;
		acc = 8'h00;
		prev = 8'h00;
		idx = 0;
		fr = 0;
		wait (run);
		// odd offset keeps the link clock out of step with the system clock
		#3;
		forever begin
			byte_v = 8'(idx * 7 + fr * 13 + 3);
			if (idx == int'(tco_pkg::B3_IDX))
				byte_v = prev ^ b3_flip;
			// data moves on the falling edge, well away from the sampled edge
			container_data_in = byte_v;
			container_frame_start_in = (idx == 0);
			acc = acc ^ byte_v;
			#40 container_clock_in = 1'b1;
			#40 container_clock_in = 1'b0;
			idx++;
			if (idx == FRAME_BYTES) begin
				prev = acc;
				acc = 8'h00;
				idx = 0;
				fr++;
			end
		end
	end
endmodule
